// >>> rtl/door_status_pkg.sv
/*
 Package for the door status word packer: register offsets, field positions,
 encodings and reset values. Assumes a 32-bit APB slave, one word per register.
*/
package door_status_pkg;

  // ----------------------------------------------------------------
  // Register offsets (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [11:0] OFF_STATUS_ZERO = 12'h000;
  localparam logic [11:0] OFF_STATUS_ONE = 12'h004;
  localparam logic [11:0] OFF_EVT_STATUS = 12'h008;
  localparam logic [11:0] OFF_EVT_ENABLE = 12'h00c;
  localparam logic [11:0] OFF_EVT_CLEAR = 12'h010;
  localparam logic [11:0] OFF_CTRL = 12'h014;

  // ----------------------------------------------------------------
  // Word zero fields
  // ----------------------------------------------------------------
  localparam int STATE_LSB = 0;
  localparam int STATE_W = 3;
  localparam int MODE_LSB = 3;
  localparam int MODE_W = 3;
  localparam int WAIT_BIT = 6;
  localparam int MOTOR_BIT = 7;
  localparam int UNLOCK_BIT = 8;
  localparam int REVERSE_BIT = 9;
  localparam int OBST_CLS_BIT = 10;
  localparam int OBST_OPN_BIT = 11;

  // ----------------------------------------------------------------
  // Word one fields
  // ----------------------------------------------------------------
  localparam int CLS_FORCE_LSB = 0;
  localparam int OPN_FORCE_LSB = 3;
  localparam int FORCE_W = 3;
  localparam int OBST_DIR_LSB = 6;
  localparam int OBST_RESP_BIT = 8;
  localparam int STATUS_DISPLAY_CODE_LSB = 9;
  localparam int STATUS_DISPLAY_CODE_W = 7;

  // ----------------------------------------------------------------
  // Event bits, control bits, reset values
  // ----------------------------------------------------------------
  localparam int EVT_W = 4;
  localparam int EVT_STATE_CHG = 0;
  localparam int EVT_OBST_CLS = 1;
  localparam int EVT_OBST_OPN = 2;
  localparam int EVT_FAULT = 3;
  localparam int CTRL_FREEZE_BIT = 0;
  localparam logic [15:0] WORD_RST = 16'h0000;
  localparam logic [EVT_W-1:0] EVT_RST = 4'h0;

  typedef enum logic [2:0] {
    DS_UNKNOWN = 3'b000,
    DS_UNPOWERED = 3'b001,
    DS_CLOSING = 3'b010,
    DS_OPENING = 3'b011,
    DS_HALTED = 3'b100,
    DS_CLOSED = 3'b101,
    DS_OPEN = 3'b110,
    DS_ERROR = 3'b111
  } door_state_t;

  typedef enum logic [2:0] {
    DM_UNDEFINED = 3'b000,
    DM_LEARN = 3'b001,
    DM_INITIAL = 3'b010,
    DM_NORMAL = 3'b011,
    DM_FAULT = 3'b100
  } door_mode_t;

  // Force deviation class codes
  localparam logic [2:0] FORCE_NA = 3'h0;
  localparam logic [2:0] FORCE_NOMINAL = 3'h4;
  localparam logic [6:0] STATUS_DISPLAY_CODE_NONE = 7'h00;

endpackage

// >>> rtl/sticky_event.sv
/*
 One sticky event flag: set by a hardware pulse, cleared by software.
 Assumes set and clear are synchronous to pclk.
*/
`timescale 1ns/1ps
module sticky_event (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic set_pulse,
  input wire logic clr_pulse,
  output logic flag_ff
);

  // Set wins so an event in the clear cycle is kept
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flag_ff <= 1'b0;
    end else if (set_pulse) begin
      flag_ff <= 1'b1;
    end else if (clr_pulse) begin
      flag_ff <= 1'b0;
    end
  end

endmodule // sticky_event

// >>> rtl/door_status_word_packer.sv
/*
 Door status word packer: assembles the two technology status words from the
 door controller's state and exposes them over an APB slave with events.
 Assumes all status inputs are synchronous to pclk and come from the door logic.
*/
`timescale 1ns/1ps

module door_status_word_packer
  import door_status_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [2:0] door_state,
  input wire logic [2:0] door_operating_mode,
  input wire logic command_wait_flag,
  input wire logic motor_energized_flag,
  input wire logic emergency_unlock_flag,
  input wire logic direction_reversing_flag,
  input wire logic obstacle_closing_flag,
  input wire logic obstacle_opening_flag,
  input wire logic [2:0] closing_force_deviation,
  input wire logic [2:0] opening_force_deviation,
  input wire logic [1:0] obstruction_direction_bits,
  input wire logic obstruction_response_flag,
  input wire logic [6:0] status_display_code,
  output logic [15:0] status_zero_word,
  output logic [15:0] status_one_word,
  output logic irq
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic [15:0] word_zero_ff;
  logic [15:0] word_one_ff;
  logic [15:0] nxt_word_zero;
  logic [15:0] nxt_word_one;
  logic [2:0] prev_state_ff;
  logic prev_obst_cls_ff;
  logic prev_obst_opn_ff;
  logic prev_fault_ff;
  logic [EVT_W-1:0] evt_set;
  logic [EVT_W-1:0] evt_clr;
  logic [EVT_W-1:0] evt_status;
  logic [EVT_W-1:0] evt_enable_ff;
  logic freeze_ff;
  logic [31:0] prdata_ff;
  logic pslverr_ff;
  logic acc;
  logic wr;
  logic rd;
  logic mapped;
  logic [31:0] rd_mux;
  door_state_t state_code;
  door_mode_t mode_code;
  logic fault_now;
  logic read_only;

  // ----------------------------------------------------------------
  // Field decode
  // ----------------------------------------------------------------
  assign state_code = door_state_t'(door_state);
  assign mode_code = door_operating_mode_cast(door_operating_mode);
  // Fault seen either as error state or fault mode
  assign fault_now = (state_code == DS_ERROR) || (mode_code == DM_FAULT);

  function automatic door_mode_t door_operating_mode_cast(input logic [2:0] m);
    door_mode_t r;
    r = DM_UNDEFINED;
    case (m)
      3'b000: r = DM_UNDEFINED;
      3'b001: r = DM_LEARN;
      3'b010: r = DM_INITIAL;
      3'b011: r = DM_NORMAL;
      3'b100: r = DM_FAULT;
      default: r = DM_UNDEFINED;
    endcase
    return r;
  endfunction

  // ----------------------------------------------------------------
  // Word zero assembly
  // ----------------------------------------------------------------
  always_comb begin
    nxt_word_zero = WORD_RST;
    nxt_word_zero[STATE_LSB +: STATE_W] = state_code;
    nxt_word_zero[MODE_LSB +: MODE_W] = mode_code;
    nxt_word_zero[WAIT_BIT] = command_wait_flag;
    nxt_word_zero[MOTOR_BIT] = motor_energized_flag;
    nxt_word_zero[UNLOCK_BIT] = emergency_unlock_flag;
    nxt_word_zero[REVERSE_BIT] = direction_reversing_flag;
    nxt_word_zero[OBST_CLS_BIT] = obstacle_closing_flag;
    nxt_word_zero[OBST_OPN_BIT] = obstacle_opening_flag;
    // upper nibble stays zero from the reset value
  end

  // ----------------------------------------------------------------
  // Word one assembly
  // ----------------------------------------------------------------
  always_comb begin
    nxt_word_one = WORD_RST;
    nxt_word_one[CLS_FORCE_LSB +: FORCE_W] = closing_force_deviation;
    nxt_word_one[OPN_FORCE_LSB +: FORCE_W] = opening_force_deviation;
    nxt_word_one[OBST_DIR_LSB +: 2] = obstruction_direction_bits;
    nxt_word_one[OBST_RESP_BIT] = obstruction_response_flag;
    nxt_word_one[STATUS_DISPLAY_CODE_LSB +: STATUS_DISPLAY_CODE_W] = status_display_code;
  end

  // ----------------------------------------------------------------
  // Status word registers
  // ----------------------------------------------------------------
  // Freeze holds both words so software reads a coherent pair
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      word_zero_ff <= WORD_RST;
    end else if (!freeze_ff) begin
      word_zero_ff <= nxt_word_zero;
    end
  end

  // Same gate as word zero, so the pair never splits
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      word_one_ff <= WORD_RST;
    end else if (!freeze_ff) begin
      word_one_ff <= nxt_word_one;
    end
  end

  assign status_zero_word = word_zero_ff;
  assign status_one_word = word_one_ff;

  // ----------------------------------------------------------------
  // Event detection
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prev_state_ff <= 3'h0;
      prev_obst_cls_ff <= 1'b0;
      prev_obst_opn_ff <= 1'b0;
      prev_fault_ff <= 1'b0;
    end else begin
      prev_state_ff <= door_state;
      prev_obst_cls_ff <= obstacle_closing_flag;
      prev_obst_opn_ff <= obstacle_opening_flag;
      prev_fault_ff <= fault_now;
    end
  end

  always_comb begin
    evt_set = EVT_RST;
    evt_set[EVT_STATE_CHG] = (door_state != prev_state_ff);
    evt_set[EVT_OBST_CLS] = obstacle_closing_flag && !prev_obst_cls_ff;
    evt_set[EVT_OBST_OPN] = obstacle_opening_flag && !prev_obst_opn_ff;
    evt_set[EVT_FAULT] = fault_now && !prev_fault_ff;
  end

  // ----------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------
  // Zero wait states: every access completes in its first access cycle
  assign acc = psel && penable;
  assign wr = acc && pwrite;
  assign rd = acc && !pwrite;
  assign evt_clr = (wr && (paddr == OFF_EVT_CLEAR) && pstrb[0]) ? pwdata[EVT_W-1:0] : EVT_RST;

  // Writes to read-only words are refused rather than dropped
  always_comb begin
    mapped = 1'b0;
    read_only = 1'b0;
    case (paddr)
      OFF_STATUS_ZERO: begin
        mapped = 1'b1;
        read_only = 1'b1;
      end
      OFF_STATUS_ONE: begin
        mapped = 1'b1;
        read_only = 1'b1;
      end
      OFF_EVT_STATUS: begin
        mapped = 1'b1;
        read_only = 1'b1;
      end
      OFF_EVT_ENABLE: mapped = 1'b1;
      OFF_EVT_CLEAR: mapped = 1'b1;
      OFF_CTRL: mapped = 1'b1;
      default: begin
        mapped = 1'b0;
        read_only = 1'b0;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Event flags
  // ----------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < EVT_W; gi++) begin : g_evt
      sticky_event u_evt (
        .pclk(pclk),
        .presetn(presetn),
        .set_pulse(evt_set[gi]),
        .clr_pulse(evt_clr[gi]),
        .flag_ff(evt_status[gi])
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // Enable and control registers
  // ----------------------------------------------------------------
  // Lane zero only; other lanes hold no bits
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      evt_enable_ff <= EVT_RST;
    end else if (wr && pstrb[0] && (paddr == OFF_EVT_ENABLE)) begin
      evt_enable_ff <= pwdata[EVT_W-1:0];
    end
  end

  // Freeze bit
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      freeze_ff <= 1'b0;
    end else if (wr && pstrb[0] && (paddr == OFF_CTRL)) begin
      freeze_ff <= pwdata[CTRL_FREEZE_BIT];
    end
  end

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  always_comb begin
    rd_mux = 32'h0000_0000;
    case (paddr)
      OFF_STATUS_ZERO: rd_mux = {16'h0000, word_zero_ff};
      OFF_STATUS_ONE: rd_mux = {16'h0000, word_one_ff};
      OFF_EVT_STATUS: rd_mux = {28'h000_0000, evt_status};
      OFF_EVT_ENABLE: rd_mux = {28'h000_0000, evt_enable_ff};
      OFF_CTRL: rd_mux = {31'h0000_0000, freeze_ff};
      // Clear register and holes read as zero
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  // Read data registered in the setup cycle so it is stable in the access
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_ff <= 32'h0000_0000;
      pslverr_ff <= 1'b0;
    end else if (psel && !penable) begin
      prdata_ff <= pwrite ? 32'h0000_0000 : rd_mux;
      pslverr_ff <= !mapped || (pwrite && read_only);
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign prdata = rd ? prdata_ff : 32'h0000_0000;
  assign pready = 1'b1;
  assign pslverr = acc ? pslverr_ff : 1'b0;
  assign irq = |(evt_status & evt_enable_ff);

endmodule // door_status_word_packer

// >>> dv/door_status_word_packer_assertions.sv
/* Checker for the door status word packer: field placement and bus answers.
 Assumes binding to the packer top; sees only its ports. */
`timescale 1ns/1ps
module door_status_word_packer_assertions
  import door_status_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [2:0] door_state,
  input wire logic [2:0] door_operating_mode,
  input wire logic command_wait_flag,
  input wire logic motor_energized_flag,
  input wire logic emergency_unlock_flag,
  input wire logic direction_reversing_flag,
  input wire logic obstacle_closing_flag,
  input wire logic obstacle_opening_flag,
  input wire logic [2:0] closing_force_deviation,
  input wire logic [2:0] opening_force_deviation,
  input wire logic [6:0] status_display_code,
  input wire logic [15:0] status_zero_word,
  input wire logic [15:0] status_one_word,
  input wire logic irq
);
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  logic frz_ff;
  logic [1:0] up_ff;
  logic [5:0] flags;
  logic [5:0] forces;
  assign flags = {obstacle_opening_flag, obstacle_closing_flag, direction_reversing_flag,
    emergency_unlock_flag, motor_energized_flag, command_wait_flag};
  assign forces = {opening_force_deviation, closing_force_deviation};
  // Freeze bit is internal, so it is mirrored from the bus
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) frz_ff <= 1'b0;
    else if (psel && penable && pwrite && pstrb[0] && paddr == OFF_CTRL) frz_ff <= pwdata[0];
  end
  // Skip the edges whose past values still date from reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) up_ff <= 2'h0;
    else if (!up_ff[1]) up_ff <= up_ff + 2'h1;
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  state_field_a: assert property (up_ff[1] && !$past(frz_ff) |->
    status_zero_word[2:0] == $past(door_state)) else $error("state field wrong");
  mode_field_a: assert property (up_ff[1] && !$past(frz_ff) |->
    status_zero_word[5:3] == ($past(door_operating_mode) > 3'h4 ? 3'h0 : $past(door_operating_mode)))
    else $error("mode field wrong");
  flag_bits_a: assert property (up_ff[1] && !$past(frz_ff) |->
    status_zero_word[11:6] == $past(flags)) else $error("flag bits wrong");
  reserved_zero_a: assert property (status_zero_word[15:12] == 4'h0) else $error("reserved bits set");
  force_fields_a: assert property (up_ff[1] && !$past(frz_ff) |->
    status_one_word[5:0] == $past(forces))
    else $error("force fields wrong");
  status_code_a: assert property (up_ff[1] && !$past(frz_ff) |->
    status_one_word[15:9] == $past(status_display_code)) else $error("status code wrong");
  ready_answer_a: assert property (psel && penable |-> pready) else $error("no ready");
  word_write_refused_a: assert property (psel && penable && pwrite && paddr[11:3] == 9'h0 |-> pslverr)
    else $error("status word write accepted");
  cover property (irq);
  cover property (frz_ff ##1 frz_ff);
  cover property (psel && penable && pslverr);
endmodule // door_status_word_packer_assertions

bind door_status_word_packer door_status_word_packer_assertions chk_i(.pclk, .presetn, .psel, .penable,
  .pwrite, .paddr, .pwdata, .pstrb, .pready, .pslverr, .door_state, .door_operating_mode, .command_wait_flag,
  .motor_energized_flag, .emergency_unlock_flag, .direction_reversing_flag, .obstacle_closing_flag,
  .obstacle_opening_flag, .closing_force_deviation, .opening_force_deviation, .status_display_code,
  .status_zero_word, .status_one_word, .irq);

// >>> dv/plc_cyclic_reader.sv
/* PLC side model: takes a copy of both status words every cycle.
 Assumes the words are synchronous to pclk. */
`timescale 1ns/1ps
module plc_cyclic_reader (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [15:0] status_zero_word,
  input wire logic [15:0] status_one_word,
  output logic [15:0] seen_zero_ff,
  output logic [15:0] seen_one_ff
);
  // Process image lags the words by one cycle, like a cyclic copy
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      seen_zero_ff <= 16'h0000;
      seen_one_ff <= 16'h0000;
    end else begin
      seen_zero_ff <= status_zero_word;
      seen_one_ff <= status_one_word;
    end
  end
endmodule // plc_cyclic_reader

// >>> dv/testbench.sv
/* Testbench: drives door inputs and APB, reads back registers and the PLC copy.
 Assumes the package offsets and the hand-over bus timing. */
`timescale 1ns/1ps
module testbench;
  import door_status_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, resp, er;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rv, ex;
  logic [3:0] pstrb;
  logic [2:0] st, md, cf, of;
  logic [5:0] fl;
  logic [1:0] dir;
  logic [6:0] code;
  logic [15:0] w0, w1, s0, s1;
  int mismatches, compares;
  door_status_word_packer dut(.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata,
    .pready, .pslverr, .door_state(st), .door_operating_mode(md), .command_wait_flag(fl[0]),
    .motor_energized_flag(fl[1]), .emergency_unlock_flag(fl[2]), .direction_reversing_flag(fl[3]),
    .obstacle_closing_flag(fl[4]), .obstacle_opening_flag(fl[5]), .closing_force_deviation(cf),
    .opening_force_deviation(of), .obstruction_direction_bits(dir), .obstruction_response_flag(resp),
    .status_display_code(code), .status_zero_word(w0), .status_one_word(w1), .irq);
  plc_cyclic_reader plc(.pclk, .presetn, .status_zero_word(w0), .status_one_word(w1),
    .seen_zero_ff(s0), .seen_one_ff(s1));
  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic print_verdict;
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin @(posedge pclk); n++; end while (pready !== 1'b1 && n < 16);
    if (pready !== 1'b1) begin chk("pready wait", 1, 0); print_verdict; end
    rv = prdata; er = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e, input string nm);
    apb(1'b0, a, 32'h0);
    chk(nm, e, rv);
  endtask
  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    {psel, penable, pwrite, paddr, pwdata, st, md, fl, cf, of, dir, resp, code} = '0;
    pstrb = 4'hf; presetn = 1'b0; mismatches = 0; compares = 0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    for (int a = 0; a < 6; a++) rd(12'(a * 4), 32'h0, "reset value");
    $display("test reset done");
    for (int i = 0; i < 8; i++) begin
      @(posedge pclk); st <= 3'(i); md <= 3'(i); fl <= {3'(i), ~3'(i)};
      repeat (3) @(posedge pclk);
      ex = {20'h0, 3'(i), ~3'(i), (i < 5) ? 3'(i) : 3'h0, 3'(i)};
      rd(OFF_STATUS_ZERO, ex, "word zero");
      chk("plc word zero", ex, {16'h0, s0});
    end
    $display("test word zero done");
    apb(1'b1, OFF_CTRL, 32'h1);
    @(posedge pclk); st <= 3'h2;
    repeat (3) @(posedge pclk);
    rd(OFF_STATUS_ZERO, ex, "frozen word");
    apb(1'b1, OFF_CTRL, 32'h0);
    repeat (3) @(posedge pclk);
    rd(OFF_STATUS_ZERO, {ex[31:3], 3'h2}, "thawed word");
    $display("test freeze done");
    // Every event source fired during the state walk
    rd(OFF_EVT_STATUS, 32'hf, "events");
    apb(1'b1, OFF_EVT_STATUS, 32'h0);
    chk("ro write error", 1, er);
    chk("irq masked", 0, irq);
    apb(1'b1, OFF_EVT_ENABLE, 32'h2);
    @(negedge pclk) chk("irq enabled", 1, irq);
    apb(1'b1, OFF_EVT_CLEAR, 32'h2);
    @(negedge pclk) chk("irq cleared", 0, irq);
    rd(OFF_EVT_STATUS, 32'hd, "events left");
    pstrb <= 4'he;
    apb(1'b1, OFF_EVT_ENABLE, 32'hf);
    pstrb <= 4'hf;
    rd(OFF_EVT_ENABLE, 32'h2, "strobe ignored");
    $display("test events done");
    for (int i = 0; i < 8; i++) begin
      @(posedge pclk); cf <= 3'(i); of <= ~3'(i); dir <= 2'(i); resp <= i[0]; code <= 7'(i * 18 + 1);
      repeat (3) @(posedge pclk);
      ex = {16'h0, 7'(i * 18 + 1), i[0], 2'(i), ~3'(i), 3'(i)};
      rd(OFF_STATUS_ONE, ex, "word one");
      chk("plc word one", ex, {16'h0, s1});
    end
    apb(1'b1, OFF_STATUS_ONE, 32'hffff);
    chk("word one write error", 1, er);
    rd(OFF_STATUS_ONE, ex, "word one kept");
    apb(1'b0, 12'h018, 32'h0);
    chk("unmapped error", 1, er);
    $display("test word one done");
    print_verdict;
  end
endmodule // testbench
